// [rmsjg_pkg.sv]
`default_nettype none
package rmsjg_pkg;
    // System clock and derived cycle counts
    localparam int SYS_CLK_HZ   = 10_000_000;
    localparam int CYC_PER_US   = SYS_CLK_HZ / 1_000_000;
    // Continuous activity that trips the jabber guard
    localparam int JAB_LIMIT_MS = 4000;
    localparam int JAB_LIMIT_CYC = JAB_LIMIT_MS * 1000 * CYC_PER_US;
    // Line silence that ends a burst of transmission
    localparam int JAB_GAP_US   = 1000;
    localparam int JAB_GAP_CYC  = JAB_GAP_US * CYC_PER_US;
    // Half period of the shared panel blink
    localparam int BLINK_MS     = 250;
    localparam int BLINK_CYC    = BLINK_MS * 1000 * CYC_PER_US;
    // Driver turnaround hold per select code, in microseconds
    localparam int TURN_US [8]  = '{1000, 500, 250, 125, 64, 32, 16, 8};
    // Register offsets and reset values
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CTRL   = 4'h4;
    localparam int CTRL_MUTE_BIT      = 0;
    localparam int CTRL_TEST_BIT      = 1;
    localparam logic [1:0] CTRL_RST   = 2'h0;
    localparam int TURN_W             = 24;

    // Jabber guard states, Gray along idle, count, cut
    typedef enum logic [1:0] {
        RMSJG_IDLE  = 2'b00,
        RMSJG_COUNT = 2'b01,
        RMSJG_CUT   = 2'b11
    } rmsjg_jab_t;

    // Turnaround hold in cycles for a select code
    function automatic logic [TURN_W-1:0] turn_cyc(input logic [2:0] sel);
        return TURN_W'(TURN_US[sel] * CYC_PER_US);
    endfunction
endpackage
`default_nettype wire

// [rmsjg_top.sv]
// Function
// - Slave cuts and alarms a terminal channel after four seconds active.
// - Each channel timed alone, judged from data lines, not control lines.
// - When the channel falls silent the timer clears and it reconnects.
// - Guard disable switch stops timing, alarm and cutting entirely.
// - Alarm mute keeps buzzer and relay outputs inactive.
// - Far loopback sends ring data received back toward its sender.
// - Near loopback returns serial port input straight back out.
// - Test switch injects a pulse train in place of serial input.
// - Slave lights a wrap indicator for each rerouting direction.
// - Loop indicator steady with monitor signal, flashing when ring fails.
// - Master transmit indicator steady when valid, flashing when invalid.
// - Level indicator lights whenever optical input exceeds threshold.
// - Sync indicator steady on valid packets, flashing on invalid ones.
// - Broadcast activity indicator per channel for local-side broadcasts.
// - Response activity indicator per channel for remote responses.
// - Three switch bits select the two-wire driver turnaround time.
// - Flow control by transparent XON/XOFF and RTS/CTS handshake.
// - Two asynchronous channels carried bit by bit, no rate limit.
// - Both serial ports sampled at system clock, well above line rates.
// - Alarm relay open normally, closed on any alarm.
// - Master alarms when a ring monitor signal fails to return.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rmsjg_top
    import rmsjg_pkg::*;
#(
    parameter int JAB_CYC   = rmsjg_pkg::JAB_LIMIT_CYC, // Jabber limit
    parameter int GAP_CYC   = rmsjg_pkg::JAB_GAP_CYC,   // Burst end gap
    parameter int BLINK_HLF = rmsjg_pkg::BLINK_CYC      // Blink half
) (
    input  wire logic        clk_sys,            // System clock
    input  wire logic        rst_n,              // Sync reset
    input  wire logic        ce,                 // Clock enable
    input  wire logic [3:0]  reg_addr,           // Register address
    input  wire logic [31:0] reg_wdata,          // Write data
    input  wire logic        reg_wr,             // Write strobe
    input  wire logic        reg_rd,             // Read strobe
    output logic      [31:0] reg_rdata,          // Read data
    input  wire logic        is_master,          // Variant strap
    input  wire logic        far_loopback_sw,    // Far loopback
    input  wire logic        near_loopback_sw,   // Near loopback
    input  wire logic        test_pulse_sw,      // Signal generator
    input  wire logic        alarm_mute_sw,      // Alarm disable
    input  wire logic        jabber_guard_disable_sw, // Guard off
    input  wire logic [2:0]  turn_sel_sw,        // Turnaround select
    input  wire logic [1:0]  term_txd,           // Terminal data in
    input  wire logic [1:0]  term_rts,           // Terminal RTS
    input  wire logic [1:0]  ring_a_optic_in,    // Ring A data
    input  wire logic [1:0]  ring_b_optic_in,    // Ring B data
    input  wire logic [1:0]  rx_level_ok,        // B,A above threshold
    input  wire logic [1:0]  rx_pkt_ok,          // B,A valid packets
    input  wire logic [1:0]  loop_mon_ok,        // B,A monitor seen
    input  wire logic [1:0]  tx_sig_ok,          // B,A transmit valid
    output logic      [1:0]  term_rxd,           // Terminal data out
    output logic      [1:0]  term_cts,           // Terminal CTS
    output logic             rs485_de_n,         // Driver enable
    output logic      [1:0]  ring_a_optic_out,   // Ring A data out
    output logic      [1:0]  ring_b_optic_out,   // Ring B data out
    output logic             bcast_ind_ch1,      // Broadcast ch1
    output logic             bcast_ind_ch2,      // Broadcast ch2
    output logic             resp_ind_ch1,       // Response ch1
    output logic             resp_ind_ch2,       // Response ch2
    output logic             ring_a_loop_ind,    // Loop A
    output logic             ring_b_loop_ind,    // Loop B
    output logic             ring_a_tx_ind,      // Master tx A
    output logic             ring_b_tx_ind,      // Master tx B
    output logic             wrap_primary_to_backup_ind, // A to B
    output logic             wrap_backup_to_primary_ind, // B to A
    output logic      [1:0]  rx_level_ind,       // B,A level
    output logic      [1:0]  rx_sync_ind,        // B,A sync
    output logic             buzzer_on,          // Audible alarm
    output logic             alarm_relay_close,  // Dry contact
    output logic      [1:0]  jabber_alarm        // Per channel cut
);
    import rmsjg_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int SW = 25;
    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;
    logic          mst;
    logic          far_s;
    logic          near_s;
    logic          test_s;
    logic          mute_s;
    logic          jgd_s;
    logic [2:0]    tsel_s;
    logic [1:0]    txd_s;
    logic [1:0]    rts_s;
    logic [1:0]    ain_s;
    logic [1:0]    bin_s;
    logic [1:0]    lvl_s;
    logic [1:0]    pkt_s;
    logic [1:0]    mon_s;
    logic [1:0]    tok_s;

    // Every strap, switch and line input crosses in; idle line level is high
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_q <= '1;
            s2_q <= '1;
        end else if (ce) begin
            s1_q <= {is_master, far_loopback_sw, near_loopback_sw,
                     test_pulse_sw, alarm_mute_sw,
                     jabber_guard_disable_sw, turn_sel_sw, term_txd,
                     term_rts, ring_a_optic_in, ring_b_optic_in,
                     rx_level_ok, rx_pkt_ok, loop_mon_ok, tx_sig_ok};
            s2_q <= s1_q;
        end
    end

    assign {mst, far_s, near_s, test_s, mute_s, jgd_s, tsel_s, txd_s,
            rts_s, ain_s, bin_s, lvl_s, pkt_s, mon_s, tok_s} = s2_q;

    ////////////////////////////////////////////////////////////////////
    // Control register and shared blink
    logic [1:0]  ctrl_q;
    logic [31:0] blink_cnt_q;
    logic        blink_q;
    logic        mute;
    logic        test;

    assign mute = mute_s | ctrl_q[CTRL_MUTE_BIT];
    assign test = test_s | ctrl_q[CTRL_TEST_BIT];

    // Software control bits
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
        end else if (ce && reg_wr && reg_addr == REG_CTRL) begin
            ctrl_q <= reg_wdata[1:0];
        end
    end

    // One divider so every flashing lamp stays in step
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else if (ce) begin
            if (blink_cnt_q == 32'(BLINK_HLF - 1)) begin
                blink_cnt_q <= '0;
                blink_q     <= ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Jabber guard, one per terminal channel
    rmsjg_jab_t  st_q  [2];
    logic [31:0] jcnt_q [2];
    logic [31:0] gap_q [2];
    logic [1:0]  gap_done;
    logic [1:0]  cut;
    logic        guard_off;

    // Master never guards; the switch also turns it off
    assign guard_off = jgd_s | mst;

    for (genvar ch = 0; ch < 2; ch++) begin : g_jab
        assign gap_done[ch] = gap_q[ch] == 32'(GAP_CYC);
        assign cut[ch]      = st_q[ch] == RMSJG_CUT;

        // Silence timer: start bits and data low restart it
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                gap_q[ch] <= 32'(GAP_CYC);
            end else if (ce) begin
                if (!txd_s[ch]) begin
                    gap_q[ch] <= '0;
                end else if (!gap_done[ch]) begin
                    gap_q[ch] <= gap_q[ch] + 32'h1;
                end
            end
        end

        // Burst timer; RTS is ignored so a stuck RTS alone never trips
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                st_q[ch]   <= RMSJG_IDLE;
                jcnt_q[ch] <= '0;
            end else if (ce) begin
                unique case (st_q[ch])
                    RMSJG_IDLE: begin
                        jcnt_q[ch] <= '0;
                        if (!guard_off && !txd_s[ch]) begin
                            st_q[ch] <= RMSJG_COUNT;
                        end
                    end
                    RMSJG_COUNT: begin
                        if (guard_off || gap_done[ch]) begin
                            st_q[ch] <= RMSJG_IDLE;
                        end else if (jcnt_q[ch] == 32'(JAB_CYC - 1)) begin
                            st_q[ch] <= RMSJG_CUT;
                        end else begin
                            jcnt_q[ch] <= jcnt_q[ch] + 32'h1;
                        end
                    end
                    RMSJG_CUT: begin
                        if (guard_off || gap_done[ch]) begin
                            st_q[ch] <= RMSJG_IDLE;
                        end
                    end
                    default: st_q[ch] <= RMSJG_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data paths
    logic [1:0] loc;
    logic [1:0] rx_sel;
    logic       a2b;
    logic       b2a;

    // Local input: test pulse, else terminal unless cut or looped
    assign loc = test ? {2{blink_q}}
               : (near_s ? 2'b11 : (txd_s | {cut[1], cut[0]}));
    // Slave wraps toward the ring whose light is lost
    assign a2b = !mst && lvl_s[0] && !lvl_s[1];
    assign b2a = !mst && lvl_s[1] && !lvl_s[0];
    assign rx_sel = lvl_s[0] ? ain_s : bin_s;

    // Ring transmitters: relay, wrap, merge local, or loop back
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ring_a_optic_out <= 2'b11;
            ring_b_optic_out <= 2'b11;
        end else if (ce) begin
            if (far_s) begin
                ring_a_optic_out <= bin_s;
                ring_b_optic_out <= ain_s;
            end else if (mst) begin
                ring_a_optic_out <= loc;
                ring_b_optic_out <= loc;
            end else begin
                ring_a_optic_out <= (b2a ? bin_s : ain_s) & loc;
                ring_b_optic_out <= (a2b ? ain_s : bin_s) & loc;
            end
        end
    end

    // Serial port out; data and XON/XOFF pass bit for bit
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            term_rxd <= 2'b11;
            term_cts <= 2'b00;
        end else if (ce) begin
            term_rxd <= near_s ? txd_s : rx_sel;
            term_cts <= rts_s & ~{cut[1], cut[0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Two-wire driver turnaround on the primary port
    logic [TURN_W-1:0] hold_q;

    // Keep driving after the last bit so the stop bit gets out
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hold_q     <= '0;
            rs485_de_n <= 1'b1;
        end else if (ce) begin
            if (!term_rxd[0]) begin
                hold_q <= turn_cyc(tsel_s);
            end else if (hold_q != '0) begin
                hold_q <= hold_q - TURN_W'(1);
            end
            rs485_de_n <= term_rxd[0] && hold_q == '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Panel indicators
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bcast_ind_ch1 <= 1'b0;
            bcast_ind_ch2 <= 1'b0;
            resp_ind_ch1  <= 1'b0;
            resp_ind_ch2  <= 1'b0;
        end else if (ce) begin
            bcast_ind_ch1 <= mst ? !loc[0] : !rx_sel[0];
            bcast_ind_ch2 <= mst ? !loc[1] : !rx_sel[1];
            resp_ind_ch1  <= mst ? !rx_sel[0] : !loc[0];
            resp_ind_ch2  <= mst ? !rx_sel[1] : !loc[1];
        end
    end

    // Loop, sync and master transmit lamps steady when healthy, blink when not; wrap and level lamps never blink
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ring_a_loop_ind <= 1'b0;
            ring_b_loop_ind <= 1'b0;
            ring_a_tx_ind   <= 1'b0;
            ring_b_tx_ind   <= 1'b0;
            wrap_primary_to_backup_ind <= 1'b0;
            wrap_backup_to_primary_ind <= 1'b0;
            rx_level_ind    <= 2'b00;
            rx_sync_ind     <= 2'b00;
        end else if (ce) begin
            ring_a_loop_ind <= mon_s[0] | blink_q;
            ring_b_loop_ind <= mon_s[1] | blink_q;
            ring_a_tx_ind   <= mst && (tok_s[0] | blink_q);
            ring_b_tx_ind   <= mst && (tok_s[1] | blink_q);
            wrap_primary_to_backup_ind <= a2b;
            wrap_backup_to_primary_ind <= b2a;
            rx_level_ind    <= lvl_s;
            rx_sync_ind     <= pkt_s | {2{blink_q}};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alarm outputs
    logic ring_fault;
    logic alarm;

    assign ring_fault = mst ? !(&mon_s) : (a2b | b2a);
    assign alarm = (ring_fault | (|cut)) && !mute;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            buzzer_on         <= 1'b0;
            alarm_relay_close <= 1'b0;
            jabber_alarm      <= 2'b00;
        end else if (ce) begin
            buzzer_on         <= alarm;
            alarm_relay_close <= alarm;
            jabber_alarm      <= {cut[1], cut[0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read port; unmapped addresses read zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (ce && reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: reg_rdata <= {22'h0, mst, ring_fault, mon_s,
                                          a2b, b2a, cut[1], cut[0],
                                          lvl_s};
                REG_CTRL:   reg_rdata <= {30'h0, ctrl_q};
                default:    reg_rdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence jab_limit_s;
        ce && st_q[0] == RMSJG_COUNT && jcnt_q[0] == 32'(JAB_CYC - 1)
            && !guard_off && !gap_done[0];
    endsequence
    sequence silence_s;
        ce && st_q[0] == RMSJG_CUT && gap_done[0] && !txd_s[0] == 1'b0;
    endsequence

    jab_trip_a: assert property (jab_limit_s |=> cut[0] ##1 1'b1)
        else $error("channel not cut at jabber limit");
    jab_cts_a: assert property (ce && cut[0] |=> !term_cts[0])
        else $error("cut channel still granted CTS");
    jab_release_a: assert property (silence_s |=> !cut[0])
        else $error("channel not reconnected after silence");
    jab_disable_a: assert property (ce && guard_off |=> !cut[0])
        else $error("guard acted while disabled");
    mute_quiet_a: assert property (ce && mute |=> !buzzer_on)
        else $error("buzzer active while muted");
    far_loop_a: assert property (ce && far_s
        |=> ring_b_optic_out == $past(ain_s))
        else $error("far loopback path wrong");
    near_loop_a: assert property (ce && near_s
        |=> term_rxd == $past(txd_s))
        else $error("near loopback path wrong");
    test_pulse_a: assert property (ce && test && mst && !far_s
        |=> ring_a_optic_out == {2{$past(blink_q)}})
        else $error("test pulse not injected");
    wrap_ind_a: assert property (ce && a2b && !far_s
        |=> wrap_primary_to_backup_ind
            && ring_b_optic_out == ($past(ain_s) & $past(loc)))
        else $error("wrap indicator or path wrong");
    loop_ind_a: assert property (ce && !mon_s[0] && !blink_q
        |=> !ring_a_loop_ind)
        else $error("failed ring not flashing");
    relay_alarm_a: assert property (ce && !mute && mst && !mon_s[1]
        |=> alarm_relay_close)
        else $error("lost monitor did not close relay");
endmodule // rmsjg_top
`default_nettype wire

// [rmsjg_term_model.sv]
`timescale 1ns/100ps
`default_nettype none
module rmsjg_term_model (
    input  wire logic       clk_sys,           // System clock
    input  wire logic [1:0] term_cts,          // Clear to send
    input  wire logic [1:0] send,              // Wants to talk
    input  wire logic [1:0] pat,               // Data level to send
    input  wire logic [1:0] jam,               // Defective, streams low
    output logic      [1:0] term_txd = 2'h3,   // Data to modem
    output logic      [1:0] term_rts = 2'h0    // Request to send
);
    ////////////////////////////////////////////////////////////////////
    // Healthy terminal idles its data while CTS is low; a jammed one
    // ignores CTS, which is exactly the fault the guard must catch
    always @(posedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            term_rts[i] <= send[i] | jam[i];
            if (jam[i])
                term_txd[i] <= 1'b0;
            else
                term_txd[i] <= (send[i] && term_cts[i]) ? pat[i] : 1'b1;
        end
    end
endmodule // rmsjg_term_model
`default_nettype wire

// [tb_rmsjg_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_rmsjg_top;
    import rmsjg_pkg::*;
    localparam int JAB = 50;
    localparam int GAP = 8;
    localparam int OFF = 0;
    localparam int ON = 1;
    localparam int FL = 2;
    logic        clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, is_master = 1'b0;
    logic        far_loopback_sw = 1'b0, near_loopback_sw = 1'b0;
    logic        test_pulse_sw = 1'b0, alarm_mute_sw = 1'b0;
    logic        jabber_guard_disable_sw = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [2:0]  turn_sel_sw = 3'h5;
    logic [1:0]  ring_a_optic_in = 2'h3, ring_b_optic_in = 2'h3;
    logic [1:0]  rx_level_ok = 2'h3, rx_pkt_ok = 2'h3;
    logic [1:0]  loop_mon_ok = 2'h3, tx_sig_ok = 2'h3;
    logic [1:0]  send = 2'h0, pat = 2'h3, jam = 2'h0;
    logic [19:0] on1, on0;
    logic [31:0] rdat;
    int          checks = 0, fail_count = 0;
    wire logic [31:0] reg_rdata;
    wire logic [1:0]  term_txd, term_rts, term_rxd, term_cts;
    wire logic [1:0]  ring_a_optic_out, ring_b_optic_out, jabber_alarm;
    wire logic [1:0]  rx_level_ind, rx_sync_ind;
    wire logic rs485_de_n, bcast_ind_ch1, bcast_ind_ch2, resp_ind_ch1;
    wire logic resp_ind_ch2, ring_a_loop_ind, ring_b_loop_ind;
    wire logic ring_a_tx_ind, ring_b_tx_ind, wrap_primary_to_backup_ind;
    wire logic wrap_backup_to_primary_ind, buzzer_on, alarm_relay_close;
    wire logic [19:0] lamps;

    ////////////////////////////////////////////////////////////////////
    // All panel outputs in one vector so one watcher covers them
    assign lamps = {term_cts, jabber_alarm, alarm_relay_close, buzzer_on,
        rx_sync_ind, rx_level_ind, wrap_backup_to_primary_ind,
        wrap_primary_to_backup_ind, ring_b_tx_ind, ring_a_tx_ind,
        ring_b_loop_ind, ring_a_loop_ind, resp_ind_ch2, resp_ind_ch1,
        bcast_ind_ch2, bcast_ind_ch1};

    rmsjg_top #(.JAB_CYC(JAB), .GAP_CYC(GAP), .BLINK_HLF(4)) i_dut (
        .clk_sys, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .is_master, .far_loopback_sw, .near_loopback_sw,
        .test_pulse_sw, .alarm_mute_sw, .jabber_guard_disable_sw,
        .turn_sel_sw, .term_txd, .term_rts, .ring_a_optic_in,
        .ring_b_optic_in, .rx_level_ok, .rx_pkt_ok, .loop_mon_ok,
        .tx_sig_ok, .term_rxd, .term_cts, .rs485_de_n, .ring_a_optic_out,
        .ring_b_optic_out, .bcast_ind_ch1, .bcast_ind_ch2, .resp_ind_ch1,
        .resp_ind_ch2, .ring_a_loop_ind, .ring_b_loop_ind, .ring_a_tx_ind,
        .ring_b_tx_ind, .wrap_primary_to_backup_ind,
        .wrap_backup_to_primary_ind, .rx_level_ind, .rx_sync_ind,
        .buzzer_on, .alarm_relay_close, .jabber_alarm);

    rmsjg_term_model i_term (.clk_sys, .term_cts, .send, .pat, .jam,
        .term_txd, .term_rts);

    ////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial forever #50 clk_sys = ~clk_sys;
    initial begin
        cyc(5000);
        fail_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////
    // Shared helpers; cyc ends off the edge so reads are settled
    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rdat = reg_rdata;
    endtask
    // Three blink periods; a lamp is off, steady or flashing
    task automatic watch();
        cyc(5);
        on1 = '0;
        on0 = '0;
        repeat (24) begin
            @(negedge clk_sys);
            on1 |= lamps;
            on0 |= ~lamps;
        end
    endtask
    task automatic look(string nm, int i, logic [1:0] e);
        chk(nm, on1[i] ? (on0[i] ? 2'd2 : 2'd1) : 2'd0, e);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1 chk("reset lamps", lamps, 20'h0);
        chk("reset rxd", {rs485_de_n, term_rxd}, 3'h7);
        cyc(4);
    endtask
    task automatic t_regs();
        rd(REG_STATUS);
        chk("status", rdat, 32'h0c3);
        rd(4'h8);
        chk("unmapped", rdat, 32'h0);
    endtask
    task automatic t_loop();
        @(posedge clk_sys);
        send <= 2'h3;
        near_loopback_sw <= 1'b1;
        for (int p = 1; p < 3; p++) begin
            @(posedge clk_sys);
            pat <= p[1:0];
            cyc(9);
            chk("near loop", term_rxd, p[1:0]);
            chk("driver", rs485_de_n, p[0]);
        end
        @(posedge clk_sys);
        {near_loopback_sw, far_loopback_sw, send, pat} <= 6'h1f;
        {ring_a_optic_in, ring_b_optic_in} <= 4'h6;
        cyc(5);
        chk("far loop", {ring_a_optic_out, ring_b_optic_out}, 4'h9);
        @(posedge clk_sys);
        far_loopback_sw <= 1'b0;
        {ring_a_optic_in, ring_b_optic_in} <= 4'hf;
    endtask
    task automatic t_jab();
        @(posedge clk_sys);
        jam <= 2'h1;
        {send, pat} <= 4'hf;
        cyc(JAB + 15);
        chk("cut", {term_cts[0], jabber_alarm}, 3'h1);
        chk("idle ring", ring_a_optic_out[0], 1'b1);
        chk("alarm", {alarm_relay_close, buzzer_on}, 2'h3);
        rd(REG_STATUS);
        chk("status cut", rdat, 32'h0c7);
        @(posedge clk_sys);
        alarm_mute_sw <= 1'b1;
        cyc(4);
        chk("mute", {alarm_relay_close, buzzer_on}, 2'h0);
        @(posedge clk_sys);
        alarm_mute_sw <= 1'b0;
        wr(REG_CTRL, 32'h3);
        cyc(2);
        chk("soft mute", {alarm_relay_close, buzzer_on}, 2'h0);
        watch();
        look("soft pulse", 3, FL);
        rd(REG_CTRL);
        chk("ctrl", rdat, 32'h3);
        wr(REG_CTRL, 32'h0);
        @(posedge clk_sys);
        jam <= 2'h0;
        cyc(GAP + 10);
        chk("reconnect", {term_cts[0], jabber_alarm}, 3'h4);
        chk("alarm off", alarm_relay_close, 1'b0);
        @(posedge clk_sys);
        send <= 2'h0;
    endtask
    task automatic t_guard();
        @(posedge clk_sys);
        jabber_guard_disable_sw <= 1'b1;
        jam <= 2'h3;
        cyc(JAB + 15);
        chk("guard off", {alarm_relay_close, jabber_alarm}, 3'h0);
        @(posedge clk_sys);
        jam <= 2'h0;
        cyc(GAP + 5);
        @(posedge clk_sys);
        jabber_guard_disable_sw <= 1'b0;
    endtask
    // Slave panel: loop, sync and wrap lamps
    task automatic t_panel();
        @(posedge clk_sys);
        {loop_mon_ok, rx_pkt_ok} <= 4'h6;
        watch();
        look("loop a", 4, ON);
        look("loop b", 5, FL);
        look("sync a", 12, FL);
        look("sync b", 13, ON);
        @(posedge clk_sys);
        {loop_mon_ok, rx_pkt_ok, rx_level_ok} <= 6'h3d;
        watch();
        look("wrap ab", 8, ON);
        look("wrap ba", 9, OFF);
        look("level b", 11, OFF);
        look("wrap alarm", 15, ON);
        @(posedge clk_sys);
        rx_level_ok <= 2'h2;
        watch();
        look("wrap ba2", 9, ON);
        look("level a", 10, OFF);
        @(posedge clk_sys);
        rx_level_ok <= 2'h3;
    endtask
    // Master panel: transmit lamps, monitor alarm, test pulse, activity
    task automatic t_master();
        @(posedge clk_sys);
        is_master <= 1'b1;
        {tx_sig_ok, loop_mon_ok} <= 4'h5;
        watch();
        look("tx a", 6, ON);
        look("tx b", 7, FL);
        look("mon alarm", 15, ON);
        look("master wrap", 8, OFF);
        @(posedge clk_sys);
        {tx_sig_ok, loop_mon_ok, test_pulse_sw} <= 5'h1f;
        watch();
        look("pulse ch1", 0, FL);
        look("pulse ch2", 1, FL);
        @(posedge clk_sys);
        test_pulse_sw <= 1'b0;
        ring_a_optic_in <= 2'h2;
        watch();
        chk("resp lamps", {on1[3], on1[2]}, 2'h1);
        @(posedge clk_sys);
        ring_a_optic_in <= 2'h3;
        is_master <= 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        t_reset();
        t_regs();
        t_loop();
        t_jab();
        t_guard();
        t_panel();
        t_master();
        close_out();
    end
endmodule // tb_rmsjg_top
`default_nettype wire
